/* File: dv/mms_cpu_model.sv */
// processor model facing the management-mode controller.
// assumes it shares clk_sys and rst_b with the controller.
`timescale 1ns/1ns
module mms_cpu_model #(
  parameter int ENTRY_DLY = 3,
  parameter int MODE_LEN = 12
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic mgmt_interrupt_req_b,
  input wire logic soft_reset_in_b,
  input wire logic ads_req,
  output logic mgmt_mode_active_b,
  output logic cpu_ads
);
  int cnt;
  ////////////////////////////////////////////////////////////
  // a bus cycle starts only when the bench asks, to cut the exit hold short
  assign cpu_ads = ads_req;
  // drain, then mode-active; timed exit; it never flushes by itself
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      mgmt_mode_active_b <= 1'b1;
      cnt <= 0;
    end else if (mgmt_mode_active_b) begin
      // a soft reset in progress wins over the request
      if (!mgmt_interrupt_req_b && soft_reset_in_b) begin
        cnt <= cnt + 1;
        if (cnt == ENTRY_DLY) begin
          mgmt_mode_active_b <= 1'b0;
          cnt <= 0;
        end
      end
    end else begin
      // timed exit; a request still low after it is served first
      cnt <= cnt + 1;
      if (cnt == MODE_LEN) begin
        mgmt_mode_active_b <= 1'b1;
        cnt <= 0;
      end
    end
  end
endmodule : mms_cpu_model

/* File: dv/test_mms_ctrl.sv */
// self-checking bench for the management-mode controller.
// assumes the processor model on the far side and one 100 MHz clock.
`timescale 1ns/1ns
module test_mms_ctrl;
  import mms_pkg::*;
  logic clk_sys = 1'b0, rst_b = 1'b0, cfg_writeback = 1'b0;
  logic cfg_overlaid = 1'b0, cfg_cache_in_mgmt = 1'b0, cfg_kill_cache = 1'b0;
  logic mgmt_ram_ready = 1'b1, mgmt_ram_open = 1'b0, sys_mgmt_req = 1'b0;
  logic sys_addr_bit20_mask_b = 1'b1, sys_soft_reset_req = 1'b0;
  logic sys_hard_reset = 1'b0, acc_valid = 1'b0, acc_is_cpu = 1'b0;
  logic wr_valid = 1'b0, mem_ready = 1'b0, flush_q = 1'b1, ads_req = 1'b0;
  logic [ADDR_W-1:0] acc_addr = '0, wr_addr = '0, mem_addr;
  logic [DATA_W-1:0] wr_data = '0, mem_data;
  logic mgmt_interrupt_req_b, mgmt_mode_active_b, cpu_ads, flush_b, l2_flush;
  logic cache_enable_in_b, writeback_select, addr_bit20_mask_b;
  logic soft_reset_in_b, hard_reset_out, acc_to_mgmt_ram, acc_to_main;
  logic acc_deny, wr_ready, mem_valid, mem_to_mgmt_ram;
  int failures = 0, checks = 0, flushes = 0, cycles = 0;

  mms_ctrl u_mms_ctrl (.clk_sys, .rst_b, .cfg_writeback, .cfg_overlaid,
    .cfg_cache_in_mgmt, .cfg_kill_cache, .mgmt_ram_ready, .mgmt_ram_open,
    .sys_mgmt_req, .mgmt_interrupt_req_b, .mgmt_mode_active_b, .cpu_ads,
    .flush_b, .l2_flush, .cache_enable_in_b, .writeback_select,
    .sys_addr_bit20_mask_b, .addr_bit20_mask_b, .sys_soft_reset_req,
    .soft_reset_in_b, .sys_hard_reset, .hard_reset_out, .acc_valid,
    .acc_is_cpu, .acc_addr, .acc_to_mgmt_ram, .acc_to_main, .acc_deny,
    .wr_valid, .wr_ready, .wr_addr, .wr_data, .mem_valid, .mem_ready,
    .mem_addr, .mem_data, .mem_to_mgmt_ram);
  mms_cpu_model u_mms_cpu_model (.clk_sys, .rst_b, .mgmt_interrupt_req_b,
    .soft_reset_in_b, .ads_req, .mgmt_mode_active_b, .cpu_ads);

  ////////////////////////////////////////////////////////////
  always #5 clk_sys = ~clk_sys;
  // flush pulse counter and hang guard; the run needs well under 2000
  always @(posedge clk_sys) begin
    cycles++;
    flush_q <= flush_b;
    if (flush_q && !flush_b) flushes++;
    if (cycles == 5000) begin
      failures++;
      test_done();
    end
  end

  task automatic test_done;
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic chk(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task automatic chkw(input string what, input logic [DATA_W-1:0] exp,
    input logic [DATA_W-1:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chkw
  task automatic set_cfg(input logic wb, ov, cache, kill);
    cfg_writeback = wb;
    cfg_overlaid = ov;
    cfg_cache_in_mgmt = cache;
    cfg_kill_cache = kill;
    acc_valid = 1'b0;
    step(2);
  endtask : set_cfg
  // request one entry, return three cycles into the mode
  task automatic enter_mode;
    sys_mgmt_req = 1'b1;
    step(1);
    sys_mgmt_req = 1'b0;
    chk("req_b", 1'b0, mgmt_interrupt_req_b);
    while (mgmt_mode_active_b !== 1'b0) step(1);
    step(3);
  endtask : enter_mode
  task automatic leave_mode;
    while (mgmt_mode_active_b !== 1'b1) step(1);
    step(25);
  endtask : leave_mode
  // combinational decode, judged one cycle after the inputs change
  task automatic dec(input logic ov, cpu, opn, input logic [ADDR_W-1:0] a,
    input logic [2:0] exp);
    cfg_overlaid = ov;
    acc_is_cpu = cpu;
    mgmt_ram_open = opn;
    acc_addr = a;
    acc_valid = 1'b1;
    step(1);
    chk("acc_mgmt", exp[2], acc_to_mgmt_ram);
    chk("acc_main", exp[1], acc_to_main);
    chk("acc_deny", exp[0], acc_deny);
  endtask : dec
  task automatic push(input logic [ADDR_W-1:0] a);
    wr_addr = a;
    wr_data = ~a;
    wr_valid = 1'b1;
    while (wr_ready !== 1'b1) step(1);
    step(1);
    wr_valid = 1'b0;
    step(1);
  endtask : push

  task automatic t_refuse;
    mgmt_ram_ready = 1'b0;
    sys_mgmt_req = 1'b1;
    step(3);
    sys_mgmt_req = 1'b0;
    chk("req_refused", 1'b1, mgmt_interrupt_req_b);
    mgmt_ram_ready = 1'b1;
    step(2);
    chk("req_not_kept", 1'b1, mgmt_interrupt_req_b);
  endtask : t_refuse
  task automatic t_decode;
    dec(1'b1, 1'b1, 1'b1, 32'h0003_8000, 3'b100);
    dec(1'b1, 1'b1, 1'b0, 32'h0003_ffff, 3'b010);
    dec(1'b1, 1'b1, 1'b1, 32'h0004_0000, 3'b010);
    dec(1'b1, 1'b1, 1'b1, 32'h0003_7fff, 3'b010);
    dec(1'b1, 1'b0, 1'b1, 32'h0003_8000, 3'b010);
    dec(1'b0, 1'b0, 1'b1, 32'h0003_8000, 3'b001);
    dec(1'b0, 1'b1, 1'b0, 32'h0003_8000, 3'b001);
    mgmt_ram_open = 1'b0;
  endtask : t_decode
  task automatic t_wt_flush;
    set_cfg(1'b0, 1'b1, 1'b1, 1'b0);
    flushes = 0;
    enter_mode();
    chk("flush_entry", 1'b1, flushes == 1);
    leave_mode();
    chk("flush_exit", 1'b1, flushes == 2);
  endtask : t_wt_flush
  task automatic t_wb_flush;
    set_cfg(1'b1, 1'b1, 1'b1, 1'b0);
    flushes = 0;
    sys_mgmt_req = 1'b1;
    step(1);
    sys_mgmt_req = 1'b0;
    chk("flush_b", 1'b0, flush_b);
    chk("l2_flush", 1'b1, l2_flush);
    chk("cache_off", 1'b1, cache_enable_in_b);
    // the exit wait only means something once the mode has begun
    while (mgmt_mode_active_b !== 1'b0) step(1);
    leave_mode();
    chk("one_flush", 1'b1, flushes == 1);
  endtask : t_wb_flush
  // separate ram, write-back: force write-through or switch caching off
  task automatic t_sep(input logic kill);
    set_cfg(1'b1, 1'b0, 1'b1, kill);
    chk("wb_sel_idle", 1'b1, writeback_select);
    enter_mode();
    chk("wb_sel_mode", kill, writeback_select);
    chk("cache_off", kill, cache_enable_in_b);
    leave_mode();
    chk("wb_sel_back", 1'b1, writeback_select);
  endtask : t_sep
  task automatic t_a20;
    set_cfg(1'b0, 1'b0, 1'b1, 1'b0);
    sys_addr_bit20_mask_b = 1'b0;
    step(2);
    chk("a20_idle", 1'b0, addr_bit20_mask_b);
    enter_mode();
    chk("a20_mode", 1'b1, addr_bit20_mask_b);
    leave_mode();
    chk("a20_back", 1'b0, addr_bit20_mask_b);
    sys_addr_bit20_mask_b = 1'b1;
  endtask : t_a20
  task automatic t_srst;
    enter_mode();
    sys_soft_reset_req = 1'b1;
    step(1);
    sys_soft_reset_req = 1'b0;
    while (mgmt_mode_active_b !== 1'b1) begin
      chk("srst_mode", 1'b1, soft_reset_in_b);
      step(1);
    end
    repeat (19) begin
      chk("srst_hold", 1'b1, soft_reset_in_b);
      step(1);
    end
    repeat (8) if (soft_reset_in_b !== 1'b0) step(1);
    chk("srst_late", 1'b0, soft_reset_in_b);
    step(8);
    sys_hard_reset = 1'b1;
    step(1);
    sys_hard_reset = 1'b0;
    chk("hard_rst", 1'b1, hard_reset_out);
    step(2);
  endtask : t_srst
  // a bus cycle start ends the exit hold early; hard reset passes in mode
  task automatic t_srst_ads;
    enter_mode();
    sys_hard_reset = 1'b1;
    step(1);
    sys_hard_reset = 1'b0;
    chk("hard_rst_mode", 1'b1, hard_reset_out);
    sys_soft_reset_req = 1'b1;
    step(1);
    sys_soft_reset_req = 1'b0;
    while (mgmt_mode_active_b !== 1'b1) step(1);
    step(2);
    chk("srst_pre_ads", 1'b1, soft_reset_in_b);
    ads_req = 1'b1;
    step(1);
    ads_req = 1'b0;
    step(1);
    chk("srst_ads", 1'b0, soft_reset_in_b);
    step(8);
  endtask : t_srst_ads
  // memory side stalls while one word is buffered in mode, one after
  task automatic t_wbuf;
    set_cfg(1'b0, 1'b1, 1'b0, 1'b0);
    enter_mode();
    dec(1'b1, 1'b1, 1'b0, 32'h0003_8000, 3'b100);
    push(32'h0003_8010);
    leave_mode();
    push(32'h0003_8020);
    while (mem_valid !== 1'b1) step(1);
    chk("tag_mode", 1'b1, mem_to_mgmt_ram);
    chkw("mem_addr", 32'h0003_8010, mem_addr);
    chkw("mem_data", ~32'h0003_8010, mem_data);
    mem_ready = 1'b1;
    step(1);
    chk("second_word", 1'b1, mem_valid);
    chk("tag_normal", 1'b0, mem_to_mgmt_ram);
    chkw("mem_addr2", 32'h0003_8020, mem_addr);
    step(1);
    mem_ready = 1'b0;
    chk("drained", 1'b0, mem_valid);
    // four words with the memory side stalled fill the buffer
    repeat (4) push(32'h0004_0000);
    chk("wr_full", 1'b0, wr_ready);
  endtask : t_wbuf

  initial begin
    step(8);
    chk("rst_req", 1'b1, mgmt_interrupt_req_b);
    chk("rst_flush", 1'b1, flush_b);
    chk("rst_srst", 1'b1, soft_reset_in_b);
    chk("rst_a20", 1'b1, addr_bit20_mask_b);
    rst_b = 1'b1;
    step(1);
    t_refuse();
    t_decode();
    t_wt_flush();
    t_wb_flush();
    t_sep(1'b0);
    t_sep(1'b1);
    t_a20();
    t_srst();
    t_srst_ads();
    t_wbuf();
    test_done();
  end
endmodule : test_mms_ctrl

/* File: rtl/mms_ctrl.sv */
// chipset-side controller for the processor's management mode.
// assumes processor pins are synchronous to clk_sys, the request and
// mode-active pins are active low, and a bus cycle start is flagged by cpu_ads.
// Summary of operation
// - boot opens ram; no request before ready
// - decode 38000h window as management ram
// - other masters never reach management ram
// - write-back non-overlaid caching: force write-through
// - optionally disable caching with the request
// - mode-active steers overlaid accesses, processor only
// - write-through overlaid: flush on mode entry
// - caching kept: flush again at exit
// - cache disabled at flush: no second flush
// - write-back overlaid: flush with request, disable
// - mask inactive across save and restore
// - block soft reset, never hard reset
// - keep blocking 20 clocks or bus start
// - latch blocked soft reset, deliver later
// - write buffer entries carry mode tag
`timescale 1ns/1ns
module mms_ctrl
  import mms_pkg::*;
(
  input logic clk_sys,
  input logic rst_b,
  input logic cfg_writeback,
  input logic cfg_overlaid,
  input logic cfg_cache_in_mgmt,
  input logic cfg_kill_cache,
  input logic mgmt_ram_ready,
  input logic mgmt_ram_open,
  input logic sys_mgmt_req,
  output logic mgmt_interrupt_req_b,
  input logic mgmt_mode_active_b,
  input logic cpu_ads,
  output logic flush_b,
  output logic l2_flush,
  output logic cache_enable_in_b,
  output logic writeback_select,
  input logic sys_addr_bit20_mask_b,
  output logic addr_bit20_mask_b,
  input logic sys_soft_reset_req,
  output logic soft_reset_in_b,
  input logic sys_hard_reset,
  output logic hard_reset_out,
  input logic acc_valid,
  input logic acc_is_cpu,
  input logic [mms_pkg::ADDR_W-1:0] acc_addr,
  output logic acc_to_mgmt_ram,
  output logic acc_to_main,
  output logic acc_deny,
  input logic wr_valid,
  output logic wr_ready,
  input logic [mms_pkg::ADDR_W-1:0] wr_addr,
  input logic [mms_pkg::DATA_W-1:0] wr_data,
  output logic mem_valid,
  input logic mem_ready,
  output logic [mms_pkg::ADDR_W-1:0] mem_addr,
  output logic [mms_pkg::DATA_W-1:0] mem_data,
  output logic mem_to_mgmt_ram
);
  import mms_pkg::*;

  mms_state_t state;
  mms_state_t next_state;
  logic mode_q;
  logic [4:0] hold_cnt;
  logic [1:0] flush_cnt;
  logic [2:0] srst_cnt;
  logic srst_pend;
  logic cache_off;

  ////////////////////////////////////////////////////////////////////////////
  // mode-active edges; the pin is active low and already synchronous
  wire mode_now = !mgmt_mode_active_b;
  wire mode_entry = mode_now && !mode_q;
  wire mode_exit = !mode_now && mode_q;
  wire cfg_wt_ovl = !cfg_writeback && cfg_overlaid;
  wire cfg_wb_ovl = cfg_writeback && cfg_overlaid;
  wire cfg_wb_sep = cfg_writeback && !cfg_overlaid;
  // no request until the handler is installed; pending resets go first
  wire req_start = (state == MMS_IDLE) && sys_mgmt_req && mgmt_ram_ready &&
                   !srst_pend && (srst_cnt == 3'h0);

  // sequencer: request, mode, post-exit hold
  always_comb begin
    next_state = state;
    case (state)
      MMS_IDLE: if (req_start) next_state = MMS_REQ;
      MMS_REQ: if (mode_now) next_state = MMS_MODE;
      MMS_MODE: if (mode_exit) next_state = MMS_EXIT;
      MMS_EXIT: begin
        // a nested request re-enters before any i/o restart
        if (mode_now) next_state = MMS_MODE;
        else if (cpu_ads || hold_cnt == 5'h01) next_state = MMS_IDLE;
      end
      default: next_state = MMS_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // flush requests: the processor never flushes on its own, so every
  // flush comes from here; write-back flushes are long, so issue only once
  wire flush_start = (req_start && cfg_wb_ovl) ||
                     (mode_entry && cfg_wt_ovl) ||
                     (mode_exit && cfg_wt_ovl && cfg_cache_in_mgmt &&
                      !cache_off);
  wire [1:0] next_flush_cnt = flush_start ? FLUSH_CNT :
                              (flush_cnt != 2'h0) ? flush_cnt - 2'h1 : 2'h0;
  // cache disable: write-back overlaid always, write-back separate on kill, write-through overlaid when not cached
  wire cache_off_set = (req_start && (cfg_wb_ovl ||
    (cfg_wb_sep && cfg_kill_cache))) ||
    (mode_entry && cfg_wt_ovl && !cfg_cache_in_mgmt);
  wire next_cache_off = cache_off_set ||
                        (cache_off && next_state != MMS_IDLE);
  // write-back, separate ram, caching kept: force write-through
  wire wt_force = (next_state != MMS_IDLE) && cfg_wb_sep &&
                  cfg_cache_in_mgmt && !cfg_kill_cache;
  wire blocked = (next_state != MMS_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // soft reset: latched while blocked, set wins over delivery
  wire srst_deliver = srst_pend && (state == MMS_IDLE) &&
                      (next_state == MMS_IDLE) && (srst_cnt == 3'h0);
  wire next_srst_pend = sys_soft_reset_req ||
                        (srst_pend && !srst_deliver);
  wire [2:0] next_srst_cnt = srst_deliver ? SRST_CNT :
                             (srst_cnt != 3'h0) ? srst_cnt - 3'h1 : 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // access routing for the overlaid or separate management ram window
  wire acc_in_rng = mms_in_mgmt_range(acc_addr);
  wire mgmt_visible = mode_now || mgmt_ram_open;
  assign acc_to_mgmt_ram = acc_valid && acc_in_rng && acc_is_cpu &&
                           mgmt_visible;
  assign acc_deny = acc_valid && acc_in_rng && !acc_to_mgmt_ram &&
                    !cfg_overlaid;
  assign acc_to_main = acc_valid && !acc_to_mgmt_ram && !acc_deny;

  // state and counters
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= MMS_IDLE;
      mode_q <= 1'b0;
      hold_cnt <= 5'h00;
      flush_cnt <= 2'h0;
      srst_cnt <= 3'h0;
      srst_pend <= 1'b0;
      cache_off <= 1'b0;
    end else begin
      state <= next_state;
      mode_q <= mode_now;
      hold_cnt <= mode_exit ? EXIT_HOLD_CNT :
                  (hold_cnt != 5'h00) ? hold_cnt - 5'h01 : 5'h00;
      flush_cnt <= next_flush_cnt;
      srst_cnt <= next_srst_cnt;
      srst_pend <= next_srst_pend;
      cache_off <= next_cache_off;
    end
  end

  // pin drivers, all registered; hard reset passes straight through
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mgmt_interrupt_req_b <= 1'b1;
      flush_b <= 1'b1;
      l2_flush <= 1'b0;
      cache_enable_in_b <= 1'b0;
      writeback_select <= 1'b0;
      addr_bit20_mask_b <= 1'b1;
      soft_reset_in_b <= 1'b1;
      hard_reset_out <= 1'b0;
    end else begin
      mgmt_interrupt_req_b <= !(next_state == MMS_REQ);
      flush_b <= (next_flush_cnt == 2'h0);
      l2_flush <= (next_flush_cnt != 2'h0);
      cache_enable_in_b <= next_cache_off;
      writeback_select <= cfg_writeback && !wt_force;
      addr_bit20_mask_b <= sys_addr_bit20_mask_b || blocked;
      soft_reset_in_b <= (next_srst_cnt == 3'h0);
      hard_reset_out <= sys_hard_reset;
    end
  end

  // tagged second-level write buffer
  mms_wbuf u_mms_wbuf (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wr_valid(wr_valid),
    .wr_ready(wr_ready),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_mode_tag(mode_now),
    .mem_valid(mem_valid),
    .mem_ready(mem_ready),
    .mem_addr(mem_addr),
    .mem_data(mem_data),
    .mem_to_mgmt_ram(mem_to_mgmt_ram)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_entry_flush;
    ($fell(mgmt_mode_active_b) && cfg_wt_ovl) |=> !flush_b ##1 !flush_b;
  endproperty
  a_entry_flush: assert property (p_entry_flush)
    else $error("no flush on mode entry");
  property p_exit_flush;
    ($rose(mgmt_mode_active_b) && cfg_wt_ovl && cfg_cache_in_mgmt &&
     !cache_off) |=> (!flush_b && l2_flush);
  endproperty
  a_exit_flush: assert property (p_exit_flush)
    else $error("no second flush at mode exit");
  property p_no_second_flush;
    ($rose(mgmt_mode_active_b) && cfg_wt_ovl && !cfg_cache_in_mgmt &&
     flush_b) |=> flush_b;
  endproperty
  a_no_second_flush: assert property (p_no_second_flush)
    else $error("needless flush with cache disabled");
  property p_wb_flush_with_req;
    ($fell(mgmt_interrupt_req_b) && cfg_wb_ovl) |->
      (!flush_b && cache_enable_in_b);
  endproperty
  a_wb_flush_with_req: assert property (p_wb_flush_with_req)
    else $error("write-back flush not issued with request");
  property p_wt_force;
    (mode_now && cfg_wb_sep && cfg_cache_in_mgmt && !cfg_kill_cache &&
     $stable(cfg_writeback)) |-> !writeback_select;
  endproperty
  a_wt_force: assert property (p_wt_force)
    else $error("write-through not forced in mode");
  property p_a20_off;
    (state != MMS_IDLE) |-> addr_bit20_mask_b;
  endproperty
  a_a20_off: assert property (p_a20_off)
    else $error("address bit 20 mask active in mode");
  property p_srst_blocked;
    (state != MMS_IDLE) |-> soft_reset_in_b;
  endproperty
  a_srst_blocked: assert property (p_srst_blocked)
    else $error("soft reset reached processor while blocked");
  property p_exit_hold;
    ($rose(mgmt_mode_active_b) ##1 !cpu_ads [*8]) |-> soft_reset_in_b;
  endproperty
  a_exit_hold: assert property (p_exit_hold)
    else $error("soft reset released too soon after exit");
  property p_srst_latched;
    (sys_soft_reset_req && blocked) |=> srst_pend;
  endproperty
  a_srst_latched: assert property (p_srst_latched)
    else $error("blocked soft reset lost");
  property p_hard_reset;
    ##1 (hard_reset_out == $past(sys_hard_reset));
  endproperty
  a_hard_reset: assert property (p_hard_reset)
    else $error("hard reset blocked");
  property p_dma_deny;
    (acc_valid && !acc_is_cpu && acc_in_rng) |-> !acc_to_mgmt_ram;
  endproperty
  a_dma_deny: assert property (p_dma_deny)
    else $error("other master reached management ram");
  property p_ready_gate;
    !mgmt_ram_ready |=> mgmt_interrupt_req_b;
  endproperty
  a_ready_gate: assert property (p_ready_gate)
    else $error("request issued before handler ready");

  c_full_cycle: cover property ($rose(mgmt_mode_active_b) ##[1:40]
                                (state == MMS_IDLE));
  c_wb_flush: cover property ($fell(flush_b) && cfg_wb_ovl);
  c_srst_late: cover property (srst_deliver && $past(srst_pend, 3));
  c_nested: cover property ((state == MMS_EXIT) && mode_now);
endmodule : mms_ctrl

/* File: rtl/mms_pkg.sv */
// constants, state codes and address decode shared by the management-mode
// support controller and its tagged write buffer.
// assumes one bus clock shared with the processor and the memory controller.
package mms_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  // default management ram window, overlaid on main memory
  localparam logic [ADDR_W-1:0] MGMT_RAM_BASE = 32'h0003_8000;
  localparam logic [ADDR_W-1:0] MGMT_RAM_LAST = 32'h0003_ffff;
  // processor clocks soft reset stays blocked after mode exit (bus clock)
  localparam logic [4:0] EXIT_HOLD_CNT = 5'h14;
  // cycles the flush request is held low
  localparam logic [1:0] FLUSH_CNT = 2'h2;
  // cycles of a delivered soft reset pulse
  localparam logic [2:0] SRST_CNT = 3'h4;
  // second-level write buffer shape
  localparam int WBUF_DEPTH = 4;
  localparam int WBUF_PTR_W = 2;

  typedef enum logic [1:0] {
    MMS_IDLE = 2'b00,
    MMS_REQ = 2'b01,
    MMS_MODE = 2'b10,
    MMS_EXIT = 2'b11
  } mms_state_t;

  // true when an address falls inside the management ram window
  function automatic logic mms_in_mgmt_range(input logic [ADDR_W-1:0] a);
    return (a >= MGMT_RAM_BASE) && (a <= MGMT_RAM_LAST);
  endfunction : mms_in_mgmt_range
endpackage : mms_pkg

/* File: rtl/mms_wbuf.sv */
// second-level write buffer that keeps the mode-active status per entry.
// assumes the memory side may stall; routing uses the stored tag and stored address only.
`timescale 1ns/1ns
module mms_wbuf
  import mms_pkg::*;
(
  input logic clk_sys,
  input logic rst_b,
  input logic wr_valid,
  output logic wr_ready,
  input logic [mms_pkg::ADDR_W-1:0] wr_addr,
  input logic [mms_pkg::DATA_W-1:0] wr_data,
  input logic wr_mode_tag,
  output logic mem_valid,
  input logic mem_ready,
  output logic [mms_pkg::ADDR_W-1:0] mem_addr,
  output logic [mms_pkg::DATA_W-1:0] mem_data,
  output logic mem_to_mgmt_ram
);
  import mms_pkg::*;

  logic [ADDR_W-1:0] buf_addr [WBUF_DEPTH];
  logic [DATA_W-1:0] buf_data [WBUF_DEPTH];
  logic buf_tag [WBUF_DEPTH];
  logic [WBUF_PTR_W:0] wr_ptr;
  logic [WBUF_PTR_W:0] rd_ptr;

  ////////////////////////////////////////////////////////////////////////////
  // flags and handshakes; pointers carry a wrap bit so full is honest
  wire empty = (wr_ptr == rd_ptr);
  wire full = (wr_ptr[WBUF_PTR_W] != rd_ptr[WBUF_PTR_W]) &&
              (wr_ptr[WBUF_PTR_W-1:0] == rd_ptr[WBUF_PTR_W-1:0]);
  wire push = wr_valid && !full;
  wire pop = !empty && mem_ready;
  wire [WBUF_PTR_W-1:0] rd_idx = rd_ptr[WBUF_PTR_W-1:0];
  assign wr_ready = !full;
  assign mem_valid = !empty;
  assign mem_addr = buf_addr[rd_idx];
  assign mem_data = buf_data[rd_idx];
  // the stored tag, not the live pin, picks the target memory
  assign mem_to_mgmt_ram = buf_tag[rd_idx] &&
                           mms_in_mgmt_range(buf_addr[rd_idx]);

  // storage has no reset: only entries between the pointers are ever read
  always_ff @(posedge clk_sys) begin
    if (push) begin
      buf_addr[wr_ptr[WBUF_PTR_W-1:0]] <= wr_addr;
      buf_data[wr_ptr[WBUF_PTR_W-1:0]] <= wr_data;
      buf_tag[wr_ptr[WBUF_PTR_W-1:0]] <= wr_mode_tag;
    end
  end

  // pointers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_wbuf_tag_route;
    @(posedge clk_sys) disable iff (!rst_b)
    (push && empty && wr_mode_tag && mms_in_mgmt_range(wr_addr))
      |=> (mem_valid && mem_to_mgmt_ram);
  endproperty
  a_wbuf_tag_route: assert property (p_wbuf_tag_route)
    else $error("buffered management write not routed to management ram");

  property p_wbuf_full_stall;
    @(posedge clk_sys) disable iff (!rst_b)
    (push && !pop && (wr_ptr - rd_ptr == 3'h3)) |=> !wr_ready;
  endproperty
  a_wbuf_full_stall: assert property (p_wbuf_full_stall)
    else $error("write buffer accepted beyond its depth");
endmodule : mms_wbuf
